// file: fsnv_pkg.sv
// Constants, offsets and types of the flash security and option-loading block
package fsnv_pkg;
  // Register indices; the APB byte address is four times the index
  localparam logic [13:0] IDX_CLOCK_DIVIDER = 14'h1820;
  localparam logic [13:0] IDX_OPTION_WORKING = 14'h1821;
  localparam logic [13:0] IDX_CONFIG = 14'h1823;
  localparam logic [13:0] IDX_PROTECT_WORKING = 14'h1824;
  localparam logic [13:0] IDX_STATUS = 14'h1825;
  localparam logic [13:0] IDX_COMMAND = 14'h1826;
  localparam logic [13:0] IDX_KEY_LOW = 14'h1830;
  localparam logic [13:0] IDX_KEY_HIGH = 14'h1831;
  localparam logic [13:0] IDX_KEY_COMPARE = 14'h1832;
  localparam logic [13:0] IDX_SECURITY_STATUS = 14'h1833;
  localparam logic [13:0] IDX_TRIM = 14'h1834;

  // Nonvolatile locations in the flash array
  localparam logic [15:0] NV_ADC_LOW_ADDR = 16'hFFAD;
  localparam logic [15:0] NV_ADC_HIGH_FINE_ADDR = 16'hFFAE;
  localparam logic [15:0] NV_CLOCK_TRIM_ADDR = 16'hFFAF;
  localparam logic [15:0] NV_BACKDOOR_KEY_ADDR = 16'hFFB0;
  localparam logic [15:0] NV_PROTECTION_ADDR = 16'hFFBD;
  localparam logic [15:0] NV_OPTION_ADDR = 16'hFFBF;
  localparam int NV_KEY_BYTES = 8;
  localparam logic [3:0] NV_LOAD_COUNT = 4'hD;

  // Flash geometry
  localparam int FLASH_PAGE_BYTES = 512;
  localparam int FLASH_PAGES_DEFAULT = 8;

  // Option byte fields, plus trim, config and clock divider bit positions
  localparam int OPT_KEY_ENABLE_BIT = 7;
  localparam int OPT_REDIRECT_DISABLE_BIT = 6;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam int FINE_TRIM_BIT = 0;
  localparam int KEY_ACCESS_BIT = 5;
  localparam int DIV_LOADED_BIT = 7;

  // Status register bits
  localparam int STAT_BUFFER_EMPTY_BIT = 7;
  localparam int STAT_COMPLETE_BIT = 6;
  localparam int STAT_BLANK_BIT = 2;

  // Reset values
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] PROTECT_RESET = 8'hFF;
  localparam logic [7:0] STATUS_RESET = 8'hC0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Run and low-power modes
  typedef enum logic [2:0] {
    FSNV_RUN, FSNV_WAIT, FSNV_STOP3, FSNV_STOP2, FSNV_STOP1
  } fsnv_power_t;
endpackage : fsnv_pkg

// file: fsnv_top.sv
// Flash security, nonvolatile option loading and RAM guard with an APB register slave
// Operation
// R1 - Every reset reloads the protection and option working registers from their nonvolatile flash bytes.
// R2 - An eight-byte backdoor key is kept in the nonvolatile flash area and read in beside the option bytes.
// R3 - A key comparison may lift security only while the key enable bit of the option working register is 1.
// R4 - A key attempt counts only from code running in secure memory, never from the debug port.
// R5 - With the key enable bit at 0 the key mechanism is fully off and no comparison lifts security.
// R6 - With the key off, security stays on until the flash is mass erased and then checked blank.
// R7 - After reset the part is unsecured only if the two-bit security field holds the unsecured pattern.
// R8 - While secure, RAM is refused to the debug port and to code running from non-secure memory.
// R9 - RAM is kept through wait, stop2 and stop3, and marked undefined after power-on or stop1 wakeup.
// R10 - No reset path clears or initialises RAM contents.
// R11 - The flash array is organised in 512-byte erase pages, eight or four of them.
// R12 - The fine trim bit sits in bit 0 of one nonvolatile location and the full trim byte in the next.
// R13 - Whoever changes the nonvolatile bytes erases and programs them as ordinary flash.
// R14 - A key comparison that misses any of the eight bytes leaves security as it was.
// R15 - A key unlock lasts only until the next reset, when security is derived from the reloaded option byte.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module fsnv_top #(
  parameter int FLASH_PAGES = fsnv_pkg::FLASH_PAGES_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic access_from_debug,
  input wire logic code_in_secure_mem,
  output logic flash_rd_en,
  output logic [15:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_data,
  input wire logic mass_erase_done,
  input wire logic blank_check_pass,
  input wire logic ram_req,
  input wire logic ram_req_from_debug,
  input wire logic ram_req_from_nonsecure,
  output logic ram_grant,
  output logic ram_deny,
  input wire logic [2:0] power_mode,
  input wire logic stop1_wakeup,
  output logic ram_retain,
  output logic security_engaged,
  output logic vector_redirect_off,
  output logic [7:0] clock_trim,
  output logic fine_trim
);
  import fsnv_pkg::*;

  localparam int FLASH_BYTES = FLASH_PAGES * FLASH_PAGE_BYTES;

  typedef enum logic [1:0] {LD_ADDR, LD_DATA, LD_DONE} fsnv_load_t;

  // Flash address of each step of the reset load
  function automatic logic [15:0] load_addr(input logic [3:0] step);
    case (step)
      4'h0: load_addr = NV_PROTECTION_ADDR;
      4'h1: load_addr = NV_OPTION_ADDR;
      4'h2: load_addr = NV_ADC_LOW_ADDR;
      4'h3: load_addr = NV_ADC_HIGH_FINE_ADDR;
      4'h4: load_addr = NV_CLOCK_TRIM_ADDR;
      default: load_addr = NV_BACKDOOR_KEY_ADDR + {12'h000, step - 4'h5};
    endcase
  endfunction : load_addr

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction : byte_word

  // True in the capture cycle of one load step
  function automatic logic load_capture(input fsnv_load_t state, input logic [3:0] step, input logic [3:0] want);
    load_capture = (state == LD_DATA) && (step == want);
  endfunction : load_capture

  fsnv_load_t load_state;
  logic [3:0] load_step;
  logic load_done;
  logic [7:0] option_working_reg;
  logic [7:0] protection_working_reg;
  logic [63:0] backdoor_key;
  logic [7:0] adc_low_nv;
  logic [7:0] adc_high_fine_nv;
  logic [7:0] clock_divider;
  logic [7:0] config_reg;
  logic [7:0] command_reg;
  logic [7:0] status_reg;
  logic [63:0] key_attempt;
  logic key_unlocked;
  logic key_last_fail;
  logic erased_pending;
  logic ram_undefined;
  logic secure_now;
  logic key_enable_bit;
  logic [1:0] security_state_field;

  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic [13:0] apb_idx;
  logic addr_ok;
  logic [31:0] next_prdata;

  assign key_enable_bit = option_working_reg[OPT_KEY_ENABLE_BIT];
  assign security_state_field = option_working_reg[1:0];
  // Secure while loading, so nothing slips through before the option byte arrives
  assign secure_now = !load_done || ((security_state_field != SEC_UNSECURED) && !key_unlocked); // R7

  // Access phase before pready: each transfer is taken exactly once
  assign apb_access = psel && penable && !pready;
  assign apb_wr = apb_access && pwrite && addr_ok;
  assign apb_rd = apb_access && !pwrite && addr_ok;
  assign apb_idx = paddr[15:2];

  always_comb begin
    case (apb_idx)
      IDX_CLOCK_DIVIDER, IDX_OPTION_WORKING, IDX_CONFIG, IDX_PROTECT_WORKING, IDX_STATUS,
      IDX_COMMAND, IDX_KEY_LOW, IDX_KEY_HIGH, IDX_KEY_COMPARE, IDX_SECURITY_STATUS,
      IDX_TRIM: addr_ok = (paddr[1:0] == 2'h0);
      default: addr_ok = 1'b0;
    endcase
  end

  // Reset load of the nonvolatile bytes; one flash read per step
  // Two cycles per byte: address out, then capture from the array's asynchronous read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_state <= LD_ADDR;
      load_step <= 4'h0;
      load_done <= 1'b0;
      flash_rd_en <= 1'b0;
      flash_rd_addr <= 16'h0000;
    end else begin
      case (load_state)
        LD_ADDR: begin
          flash_rd_en <= 1'b1;
          flash_rd_addr <= load_addr(load_step);
          load_state <= LD_DATA;
        end
        LD_DATA: begin
          flash_rd_en <= 1'b0;
          if (load_step == NV_LOAD_COUNT - 4'h1) begin
            load_state <= LD_DONE;
            load_done <= 1'b1;
          end else begin
            load_step <= load_step + 4'h1;
            load_state <= LD_ADDR;
          end
        end
        LD_DONE: begin
          flash_rd_en <= 1'b0;
        end
        default: begin
          load_state <= LD_ADDR;
        end
      endcase
    end
  end

  // Option byte: loaded at reset only, read-only to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_working_reg <= OPTION_RESET;
    end else if (load_capture(load_state, load_step, 4'h1)) begin
      option_working_reg <= flash_rd_data; // R1
    end
  end

  // Protection byte: loaded at reset, software may change it afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protection_working_reg <= PROTECT_RESET;
    end else if (load_capture(load_state, load_step, 4'h0)) begin
      protection_working_reg <= flash_rd_data; // R1
    end else if (apb_wr && apb_idx == IDX_PROTECT_WORKING && load_done) begin
      protection_working_reg <= pwdata[7:0];
    end
  end

  // Backdoor key and trim bytes; R13 leaves their programming to ordinary flash commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backdoor_key <= 64'h0000_0000_0000_0000;
      adc_low_nv <= BYTE_ZERO;
      adc_high_fine_nv <= BYTE_ZERO;
      clock_trim <= BYTE_ZERO;
      fine_trim <= 1'b0;
    end else if (load_state == LD_DATA) begin
      case (load_step)
        4'h2: adc_low_nv <= flash_rd_data;
        4'h3: begin
          adc_high_fine_nv <= flash_rd_data;
          fine_trim <= flash_rd_data[FINE_TRIM_BIT]; // R12
        end
        4'h4: clock_trim <= flash_rd_data; // R12
        4'h0, 4'h1: begin
        end
        default: backdoor_key[(load_step - 4'h5) * 8 +: 8] <= flash_rd_data; // R2
      endcase
    end
  end

  // Clock divider may be written once per reset
  // Bit 7 marks the divider as written; software cannot undo it before reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divider <= BYTE_ZERO;
    end else if (apb_wr && apb_idx == IDX_CLOCK_DIVIDER && !clock_divider[DIV_LOADED_BIT]) begin
      clock_divider <= {1'b1, pwdata[6:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= BYTE_ZERO;
      command_reg <= BYTE_ZERO;
    end else if (apb_wr) begin
      // Only the key-access bit is writable; the rest read as 0
      if (apb_idx == IDX_CONFIG) begin
        config_reg <= pwdata[7:0] & (8'h01 << KEY_ACCESS_BIT);
      end
      if (apb_idx == IDX_COMMAND) begin
        command_reg <= pwdata[7:0];
      end
    end
  end

  // Blank flag set by a passing blank check and cleared by a mass erase; command engine lives elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= STATUS_RESET;
    end else begin
      if (blank_check_pass) begin
        status_reg[STAT_BLANK_BIT] <= 1'b1;
      end else if (mass_erase_done) begin
        status_reg[STAT_BLANK_BIT] <= 1'b0;
      end
    end
  end

  // Key attempt bytes; the debug port has no way in
  // Neither attempt nor stored key reaches the read mux, so neither can be read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_attempt <= 64'h0000_0000_0000_0000;
    end else if (apb_wr && !access_from_debug) begin // R4
      if (apb_idx == IDX_KEY_LOW) begin
        key_attempt[31:0] <= pwdata;
      end
      if (apb_idx == IDX_KEY_HIGH) begin
        key_attempt[63:32] <= pwdata;
      end
    end
  end

  // Unlock state: cleared by every reset and only ever set afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_unlocked <= 1'b0; // R15
      key_last_fail <= 1'b0;
    end else begin
      // No retry limit: software may attempt a compare any number of times
      if (apb_wr && apb_idx == IDX_KEY_COMPARE && pwdata[0]) begin
        if (key_enable_bit && load_done && code_in_secure_mem && !access_from_debug) begin // R3 R4 R5
          if (key_attempt == backdoor_key) begin
            key_unlocked <= 1'b1;
            key_last_fail <= 1'b0;
          end else begin
            key_last_fail <= 1'b1; // R14
          end
        end else begin
          key_last_fail <= 1'b1; // R5
        end
      end
      // Mass erase followed by a passing blank check is the other way out
      if (blank_check_pass && erased_pending) begin
        key_unlocked <= 1'b1; // R6
      end
    end
  end

  // A blank check only counts if a mass erase came before it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erased_pending <= 1'b0;
    end else if (mass_erase_done) begin
      erased_pending <= 1'b1; // R6
    end else if (blank_check_pass) begin
      erased_pending <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      security_engaged <= 1'b1;
      vector_redirect_off <= 1'b0;
    end else begin
      security_engaged <= secure_now; // R7
      vector_redirect_off <= option_working_reg[OPT_REDIRECT_DISABLE_BIT];
    end
  end

  // RAM guard; the block never drives a clear, so resets leave RAM alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_grant <= 1'b0;
      ram_deny <= 1'b0;
    end else begin
      // Registered security state gates RAM, so the guard never disagrees with the security output
      if (ram_req && security_engaged && (ram_req_from_debug || ram_req_from_nonsecure)) begin
        ram_grant <= 1'b0; // R8
        ram_deny <= 1'b1; // R8
      end else begin
        ram_grant <= ram_req; // R10
        ram_deny <= 1'b0;
      end
    end
  end

  // Retention and the undefined-contents marker; set wins over the software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_retain <= 1'b1;
      ram_undefined <= 1'b1;
    end else begin
      ram_retain <= (power_mode != FSNV_STOP1); // R9
      if (stop1_wakeup) begin
        ram_undefined <= 1'b1; // R9
      end else if (apb_wr && apb_idx == IDX_SECURITY_STATUS && pwdata[4]) begin
        ram_undefined <= 1'b0;
      end
    end
  end

  // Read mux
  always_comb begin
    next_prdata = WORD_ZERO;
    case (apb_idx)
      IDX_CLOCK_DIVIDER: next_prdata = byte_word(clock_divider);
      IDX_OPTION_WORKING: next_prdata = byte_word(option_working_reg);
      IDX_CONFIG: next_prdata = byte_word(config_reg);
      IDX_PROTECT_WORKING: next_prdata = byte_word(protection_working_reg);
      IDX_STATUS: next_prdata = byte_word(status_reg);
      IDX_COMMAND: next_prdata = byte_word(command_reg);
      IDX_SECURITY_STATUS: next_prdata = {FLASH_BYTES[15:0], 8'h00, 3'h0, ram_undefined,
                                          key_last_fail, key_unlocked, load_done, secure_now}; // R11
      IDX_TRIM: next_prdata = {8'h00, adc_low_nv, adc_high_fine_nv, clock_trim};
      default: next_prdata = WORD_ZERO;
    endcase
  end

  // APB: one wait state, so every answer comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= WORD_ZERO;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access && !addr_ok;
      if (apb_rd) begin
        prdata <= next_prdata;
      end else if (apb_access) begin
        prdata <= WORD_ZERO;
      end
    end
  end
endmodule : fsnv_top

// file: fsnv_checker.sv
// Port assertions for the flash security block
`timescale 1ns/1ps
module fsnv_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic access_from_debug,
  input wire logic code_in_secure_mem,
  input wire logic flash_rd_en,
  input wire logic [15:0] flash_rd_addr,
  input wire logic ram_req,
  input wire logic ram_req_from_debug,
  input wire logic ram_req_from_nonsecure,
  input wire logic ram_grant,
  input wire logic ram_deny,
  input wire logic [2:0] power_mode,
  input wire logic ram_retain,
  input wire logic security_engaged
);
  import fsnv_pkg::*;
  logic [7:0] edge_cnt;
  logic key_cmp;
  assign key_cmp = psel && penable && !pready && pwrite && paddr == {IDX_KEY_COMPARE, 2'b00} && pwdata[0];
  // Edges since reset release, to pin each step of the load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt <= 8'h00;
    end else if (edge_cnt != 8'hFF) begin
      edge_cnt <= edge_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_load_protect: assert property (edge_cnt == 8'h01 |-> flash_rd_en && flash_rd_addr == NV_PROTECTION_ADDR)
    else $error("protection byte not read first");
  a_load_option: assert property (edge_cnt == 8'h03 |-> flash_rd_en && flash_rd_addr == NV_OPTION_ADDR)
    else $error("option byte not read second");
  a_load_key: assert property (edge_cnt == 8'h0B |-> flash_rd_en && flash_rd_addr == NV_BACKDOOR_KEY_ADDR)
    else $error("key load out of place");
  a_load_secure: assert property (edge_cnt < 8'h19 |-> security_engaged)
    else $error("unsecured during load");
  a_ram_refused: assert property (security_engaged && ram_req && (ram_req_from_debug || ram_req_from_nonsecure)
    |=> ram_deny && !ram_grant) else $error("secure ram request granted");
  a_ram_open: assert property (ram_req && !security_engaged |=> ram_grant && !ram_deny)
    else $error("open ram request refused");
  a_ram_retain: assert property (power_mode != FSNV_RUN |=> ram_retain == ($past(power_mode) != FSNV_STOP1))
    else $error("ram retention wrong for mode");
  a_key_refused: assert property (key_cmp && security_engaged && (access_from_debug || !code_in_secure_mem)
    |=> security_engaged [*2]) else $error("key accepted from wrong source");
  a_unlock_holds: assert property (!security_engaged |=> !security_engaged)
    else $error("security returned without reset");
  c_denied: cover property (ram_deny);
  c_unlock: cover property ($fell(security_engaged));
  c_stop1: cover property (!ram_retain);
endmodule : fsnv_checker

bind fsnv_top fsnv_checker u_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .access_from_debug, .code_in_secure_mem, .flash_rd_en, .flash_rd_addr, .ram_req, .ram_req_from_debug,
  .ram_req_from_nonsecure, .ram_grant, .ram_deny, .power_mode, .ram_retain, .security_engaged);

// file: fsnv_flash_model.sv
// Flash array model answering each load read combinationally, in the same cycle as the request
`timescale 1ns/1ps
module fsnv_flash_model #(
  parameter logic [63:0] KEY = 64'h0,
  parameter logic [23:0] TRIMS = 24'h0,
  parameter logic [7:0] PROT = 8'h00
) (
  input wire logic pclk,
  input wire logic flash_rd_en,
  input wire logic [15:0] flash_rd_addr,
  input wire logic [7:0] opt_byte,
  output logic [7:0] flash_rd_data
);
  import fsnv_pkg::*;
  logic [7:0] idle_data = 8'h5A;
  // Bus toggles outside a read so a late sample is caught
  always @(posedge pclk) begin
    idle_data <= ~idle_data;
  end
  // Asynchronous read: the byte stands while the read strobe is high, for the capture edge
  always_comb begin
    flash_rd_data = idle_data;
    if (flash_rd_en) begin
      case (flash_rd_addr)
        NV_PROTECTION_ADDR: flash_rd_data = PROT;
        NV_OPTION_ADDR: flash_rd_data = opt_byte;
        NV_ADC_LOW_ADDR: flash_rd_data = TRIMS[23:16];
        NV_ADC_HIGH_FINE_ADDR: flash_rd_data = TRIMS[15:8];
        NV_CLOCK_TRIM_ADDR: flash_rd_data = TRIMS[7:0];
        default: flash_rd_data = KEY[{flash_rd_addr[2:0], 3'b000} +: 8];
      endcase
    end
  end
endmodule : fsnv_flash_model

// file: testbench.sv
// Register-level bench for the flash security and option-loading block
`timescale 1ns/1ps
module testbench;
  import fsnv_pkg::*;
  localparam logic [63:0] KEY = 64'h8877_6655_4433_2211;
  localparam logic [23:0] TRIMS = 24'h3AC15C;
  localparam logic [7:0] PROT = 8'hB5;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, access_from_debug, code_in_secure_mem;
  logic flash_rd_en, mass_erase_done, blank_check_pass, stop1_wakeup, ram_req, ram_req_from_debug;
  logic ram_req_from_nonsecure, ram_grant, ram_deny, ram_retain, security_engaged, vector_redirect_off, fine_trim;
  logic [15:0] paddr, flash_rd_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] flash_rd_data, clock_trim, opt_byte;
  logic [2:0] power_mode;
  int miscompares, num_checks;

  fsnv_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .access_from_debug, .code_in_secure_mem, .flash_rd_en, .flash_rd_addr, .flash_rd_data, .mass_erase_done,
    .blank_check_pass, .ram_req, .ram_req_from_debug, .ram_req_from_nonsecure, .ram_grant, .ram_deny,
    .power_mode, .stop1_wakeup, .ram_retain, .security_engaged, .vector_redirect_off, .clock_trim, .fine_trim);
  fsnv_flash_model #(.KEY(KEY), .TRIMS(TRIMS), .PROT(PROT)) u_flash (.pclk, .flash_rd_en, .flash_rd_addr,
    .opt_byte, .flash_rd_data);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic give_up;
    miscompares++;
    end_sim();
  endtask : give_up

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1

  // One idle edge after each transfer keeps strobes from being driven twice at once
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n == 20) give_up();
  endtask : apb

  task automatic rd_reg(input logic [13:0] idx);
    apb(1'b0, idx, WORD_ZERO);
  endtask : rd_reg

  task automatic do_reset(input logic [7:0] opt);
    int n;
    presetn <= 1'b0;
    opt_byte <= opt;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    do begin
      rd_reg(IDX_SECURITY_STATUS);
      n++;
    end while (rd[1] !== 1'b1 && n < 20);
    if (n == 20) give_up();
  endtask : do_reset

  task automatic key_try(input logic [31:0] hi);
    apb(1'b1, IDX_KEY_LOW, KEY[31:0]);
    apb(1'b1, IDX_KEY_HIGH, hi);
    apb(1'b1, IDX_KEY_COMPARE, 32'h0000_0001);
    rd_reg(IDX_SECURITY_STATUS);
  endtask : key_try

  initial begin
    {psel, penable, pwrite, access_from_debug, mass_erase_done, blank_check_pass} = '0;
    {ram_req, ram_req_from_debug, ram_req_from_nonsecure, stop1_wakeup, presetn} = '0;
    code_in_secure_mem = 1'b1;
    paddr = 16'h0000;
    pwdata = WORD_ZERO;
    power_mode = FSNV_RUN;
    opt_byte = 8'h00;
    miscompares = 0;
    num_checks = 0;
    for (int s = 0; s < 4; s++) begin
      do_reset({1'b1, s[0], 4'h0, s[1:0]});
      chk1(security_engaged, s[1:0] != SEC_UNSECURED);
      chk1(vector_redirect_off, s[0]);
    end
    apb(1'b1, IDX_OPTION_WORKING, WORD_ZERO);
    rd_reg(IDX_OPTION_WORKING);
    chk32(rd, 32'h0000_00C3);
    rd_reg(IDX_PROTECT_WORKING);
    chk32(rd, {24'h0, PROT});
    rd_reg(IDX_TRIM);
    chk32(rd, {8'h00, TRIMS});
    chk1(fine_trim, TRIMS[8 + FINE_TRIM_BIT]);
    chk32({24'h0, clock_trim}, {24'h0, TRIMS[7:0]});
    rd_reg(IDX_SECURITY_STATUS);
    chk32({16'h0, rd[31:16]}, 32'(FLASH_PAGES_DEFAULT * FLASH_PAGE_BYTES));
    rd_reg(14'h1822);
    chk1(err, 1'b1);
    apb(1'b1, IDX_CLOCK_DIVIDER, 32'h0000_0013);
    apb(1'b1, IDX_CLOCK_DIVIDER, 32'h0000_002A);
    rd_reg(IDX_CLOCK_DIVIDER);
    chk32(rd, 32'h0000_0093);
    apb(1'b1, IDX_CONFIG, 32'h0000_00FF);
    rd_reg(IDX_CONFIG);
    chk32(rd, 32'h0000_0020);
    apb(1'b1, IDX_PROTECT_WORKING, 32'h0000_005A);
    rd_reg(IDX_PROTECT_WORKING);
    chk32(rd, 32'h0000_005A);
    ram_req <= 1'b1;
    ram_req_from_nonsecure <= 1'b1;
    repeat (2) @(posedge pclk);
    chk1(ram_deny, 1'b1);
    ram_req_from_nonsecure <= 1'b0;
    ram_req_from_debug <= 1'b1;
    repeat (2) @(posedge pclk);
    chk1(ram_grant, 1'b0);
    key_try(KEY[63:32] ^ 32'h0100_0000);
    chk32({28'h0, rd[3:0]}, 32'h0000_000B);
    code_in_secure_mem <= 1'b0;
    key_try(KEY[63:32]);
    chk1(rd[0], 1'b1);
    code_in_secure_mem <= 1'b1;
    access_from_debug <= 1'b1;
    key_try(KEY[63:32]);
    chk1(rd[0], 1'b1);
    access_from_debug <= 1'b0;
    key_try(KEY[63:32]);
    chk32({29'h0, rd[2:0]}, 32'h0000_0006);
    chk1(ram_grant, 1'b1);
    ram_req <= 1'b0;
    for (int m = 1; m < 5; m++) begin
      power_mode <= 3'(m);
      repeat (2) @(posedge pclk);
      chk1(ram_retain, 3'(m) != FSNV_STOP1);
    end
    power_mode <= FSNV_RUN;
    apb(1'b1, IDX_SECURITY_STATUS, 32'h0000_0010);
    rd_reg(IDX_SECURITY_STATUS);
    chk1(rd[4], 1'b0);
    stop1_wakeup <= 1'b1;
    @(posedge pclk);
    stop1_wakeup <= 1'b0;
    rd_reg(IDX_SECURITY_STATUS);
    chk1(rd[4], 1'b1);
    do_reset(8'hC3);
    chk1(security_engaged, 1'b1);
    rd_reg(IDX_PROTECT_WORKING);
    chk32(rd, {24'h0, PROT});
    do_reset(8'h03);
    key_try(KEY[63:32]);
    chk1(rd[0], 1'b1);
    mass_erase_done <= 1'b1;
    @(posedge pclk);
    mass_erase_done <= 1'b0;
    rd_reg(IDX_SECURITY_STATUS);
    chk1(rd[0], 1'b1);
    blank_check_pass <= 1'b1;
    @(posedge pclk);
    blank_check_pass <= 1'b0;
    repeat (2) @(posedge pclk);
    chk1(security_engaged, 1'b0);
    rd_reg(IDX_STATUS);
    chk32(rd, {24'h0, STATUS_RESET | (8'h01 << STAT_BLANK_BIT)});
    end_sim();
  end
endmodule : testbench
